// file: hdl/mbpl_defs.svh
`ifndef MBPL_DEFS_SVH
`define MBPL_DEFS_SVH
// ************************************************************
// widths
// ************************************************************
`define MBPL_INPAGE_W 9
`define MBPL_PAGE_W   3
`define MBPL_ADDR_W   12
`define MBPL_CODE_W   5
`define MBPL_CNT_W    8
`define MBPL_WORD_W   16
`define MBPL_FLAG_W   3
`define MBPL_ADR_W    8
// ************************************************************
// branch codes of the upper half
// ************************************************************
`define MBPL_BC_PSW_DR    5'h11
`define MBPL_BC_ROR1      5'h12
`define MBPL_BC_CARRY_ODD 5'h13
`define MBPL_BC_HOTWARM   5'h14
`define MBPL_BC_COUNT     5'h15
`define MBPL_BC_INTR      5'h16
`define MBPL_BC_FOVLAP    5'h17
`define MBPL_BC_NULL      5'h18
`define MBPL_BC_TRACK     5'h19
`define MBPL_BC_CLEAR     5'h1a
`define MBPL_BC_DIAG      5'h1b
`define MBPL_BC_CALL_UW   5'h1c
`define MBPL_BC_CALL_DP   5'h1d
`define MBPL_BC_SPARE     5'h1e
`define MBPL_BC_RETURN    5'h1f
// ************************************************************
// register byte offsets
// ************************************************************
`define MBPL_OFS_CTRL   8'h00
`define MBPL_OFS_COUNT  8'h04
`define MBPL_OFS_RESULT 8'h08
`define MBPL_OFS_ROUTE  8'h0c
`define MBPL_OFS_STATUS 8'h10
`define MBPL_OFS_TRACK  8'h14
// ************************************************************
// field positions
// ************************************************************
`define MBPL_CTRL_TRACK 0
`define MBPL_CTRL_IMM   1
`define MBPL_CTRL_FL_LO 2
`define MBPL_CTRL_FL_HI 4
`define MBPL_D_RET_HI   14
`define MBPL_D_RET_LO   3
// ************************************************************
// reset and fixed values
// ************************************************************
`define MBPL_CNT_RST  8'h00
`define MBPL_CNT_ONE  8'h01
`define MBPL_CNT_FULL 8'hff
`define MBPL_ADDR_RST 12'h000
`define MBPL_RET_RST  12'h000
`define MBPL_WORD_RST 16'h0000
`define MBPL_FLAG_RST 3'h0
`define MBPL_BUS_ZERO 32'h0000_0000
`endif

// file: hdl/mbpl_pkg.sv
`include "mbpl_defs.svh"
`default_nettype none
package mbpl_pkg;
    typedef logic [`MBPL_CODE_W-1:0] mbpl_code_t;
    // microword fields seen by the sequencer
    typedef struct packed {
        mbpl_code_t                branch_code_field;
        logic [`MBPL_INPAGE_W-1:0] next_address_field;
        logic [`MBPL_PAGE_W-1:0]   page_field;
        logic [`MBPL_PAGE_W-1:0]   saved_page_field;
        logic [`MBPL_INPAGE_W-1:0] return_addr_field;
    } mbpl_uword_t;
    // test conditions, held from the previous microcycle
    typedef struct packed {
        logic       dp_carry;
        logic       bus_addr_lsb;
        logic [1:0] cond_psw_dr;
        logic [1:0] cond_hotwarm;
        logic [1:0] cond_intr;
        logic [1:0] cond_fovlap;
    } mbpl_cond_t;
    // state effects of the active codes
    typedef struct packed {
        logic ror1;
        logic ctr_inc;
        logic track_on;
        logic clear_flags;
        logic call_uw;
        logic call_dp;
        logic ret;
    } mbpl_fx_t;
    // classic wishbone request from the master
    typedef struct packed {
        logic                   cyc;
        logic                   stb;
        logic                   we;
        logic [`MBPL_ADR_W-1:0] adr;
        logic [3:0]             sel;
        logic [31:0]            dat;
    } mbpl_wb_req_t;
endpackage
`default_nettype wire

// file: hdl/mbpl_test_mux.sv
`include "mbpl_defs.svh"
`default_nettype none
// ************************************************************
// branch test multiplexer and active-code decode
// ************************************************************
module mbpl_test_mux import mbpl_pkg::*; (
    // microword and conditions
    input  wire mbpl_uword_t             uw,
    input  wire mbpl_cond_t              cond,
    input  wire logic [`MBPL_CNT_W-1:0]  loop_counter,
    // results
    output logic [`MBPL_INPAGE_W-1:0]    test_bits,
    output mbpl_fx_t                     fx
);
    wire mbpl_code_t bc       = uw.branch_code_field;
    wire             cnt_full = (loop_counter == `MBPL_CNT_FULL);

    // bits ORed into the in-page address, low-justified
    assign test_bits =
        (bc == `MBPL_BC_PSW_DR)    ? {7'h00, cond.cond_psw_dr} :
        (bc == `MBPL_BC_CARRY_ODD) ? {7'h00, cond.dp_carry, cond.bus_addr_lsb} :
        (bc == `MBPL_BC_HOTWARM)   ? {7'h00, cond.cond_hotwarm} :
        (bc == `MBPL_BC_COUNT)     ? {8'h00, cnt_full} :
        (bc == `MBPL_BC_INTR)      ? {7'h00, cond.cond_intr} :
        (bc == `MBPL_BC_FOVLAP)    ? {7'h00, cond.cond_fovlap} :
        9'h000; // null, active codes other than count, and out-of-range codes

    // active-code effects; 33 and 36 decode to nothing
    assign fx.ror1        = (bc == `MBPL_BC_ROR1);
    assign fx.ctr_inc     = (bc == `MBPL_BC_COUNT);
    assign fx.track_on    = (bc == `MBPL_BC_TRACK);
    assign fx.clear_flags = (bc == `MBPL_BC_CLEAR);
    assign fx.call_uw     = (bc == `MBPL_BC_CALL_UW);
    assign fx.call_dp     = (bc == `MBPL_BC_CALL_DP);
    assign fx.ret         = (bc == `MBPL_BC_RETURN);
endmodule
`default_nettype wire

// file: hdl/mbpl_page_ret.sv
`include "mbpl_defs.svh"
`default_nettype none
// ************************************************************
// return register, page register and next address
// ************************************************************
module mbpl_page_ret import mbpl_pkg::*; (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      srst,
    // sequencer inputs
    input  wire mbpl_uword_t               uw,
    input  wire mbpl_fx_t                  fx,
    input  wire logic [`MBPL_INPAGE_W-1:0] in_page,
    input  wire logic [`MBPL_WORD_W-1:0]   d_out,
    input  wire logic                      forced_dispatch,
    input  wire logic [`MBPL_ADDR_W-1:0]   dispatch_addr,
    // state
    output logic [`MBPL_ADDR_W-1:0]        cs_addr_q,
    output logic [`MBPL_ADDR_W-1:0]        ret_q
);
    logic [`MBPL_ADDR_W-1:0] cs_addr_d;
    logic [`MBPL_ADDR_W-1:0] ret_d;

    wire [`MBPL_PAGE_W-1:0] page_q = cs_addr_q[`MBPL_ADDR_W-1:`MBPL_INPAGE_W];
    wire                    call   = fx.call_uw | fx.call_dp;
    wire [`MBPL_ADDR_W-1:0] ret_uw = {uw.saved_page_field, uw.return_addr_field};
    wire [`MBPL_ADDR_W-1:0] ret_dp = d_out[`MBPL_D_RET_HI:`MBPL_D_RET_LO];
    // page from the microword on a call, else held
    wire [`MBPL_PAGE_W-1:0] page_n = call ? uw.page_field : page_q;

    // return mux
    assign ret_d = fx.call_uw            ? ret_uw :
                   (fx.call_dp | fx.ret) ? ret_dp :
                   ret_q;

    // next address: dispatch jam, return, or page plus ORed field
    assign cs_addr_d = forced_dispatch ? dispatch_addr :
                       fx.ret          ? ret_q :
                       {page_n, in_page};

    // registers close at the end of each microcycle
    always_ff @(posedge clk) begin
        if (srst) begin
            cs_addr_q <= `MBPL_ADDR_RST;
            ret_q     <= `MBPL_RET_RST;
        end else begin
            cs_addr_q <= cs_addr_d;
            ret_q     <= ret_d;
        end
    end
endmodule
`default_nettype wire

// file: hdl/mbpl_top.sv
`include "mbpl_defs.svh"
`default_nettype none
module mbpl_top import mbpl_pkg::*; (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      srst,
    // current microword and test conditions
    input  wire mbpl_uword_t               uw,
    input  wire mbpl_cond_t                cond,
    // datapath output bus
    input  wire logic [`MBPL_WORD_W-1:0]   d_out,
    // dispatch jam
    input  wire logic                      forced_dispatch,
    input  wire logic [`MBPL_ADDR_W-1:0]   dispatch_addr,
    // control store address
    output logic [`MBPL_ADDR_W-1:0]        next_micro_address,
    // effects towards the rest of the processor
    output logic                           ror1_q,
    output logic                           imm_sel_q,
    output logic [`MBPL_FLAG_W-1:0]        short_flags_q,
    output logic [`MBPL_WORD_W-1:0]        result_q,
    output logic [`MBPL_WORD_W-1:0]        routing_q,
    output logic [`MBPL_CNT_W-1:0]         loop_counter_q,
    output logic                           track_en_q,
    output logic [`MBPL_ADDR_W-1:0]        tracked_addr_q,
    // wishbone slave
    input  wire mbpl_wb_req_t              wb_req,
    output logic                           wb_ack,
    output logic [31:0]                    wb_dat_r
);
    // ************************************************************
    // byte-lane merge for register writes
    // ************************************************************
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ************************************************************
    // branch test and address formation
    // ************************************************************
    logic [`MBPL_INPAGE_W-1:0] test_bits;
    mbpl_fx_t                  fx;
    logic [`MBPL_ADDR_W-1:0]   ret_q;
    logic [`MBPL_ADDR_W-1:0]   cs_addr_q;

    // counter tested is the one clocked last cycle
    mbpl_test_mux u_mux (
        .uw           (uw),
        .cond         (cond),
        .loop_counter (loop_counter_q),
        .test_bits    (test_bits),
        .fx           (fx)
    );

    // in-page address: a field bit at one is not disturbed
    wire [`MBPL_INPAGE_W-1:0] in_page = uw.next_address_field | test_bits;

    mbpl_page_ret u_page (
        .clk             (clk),
        .srst            (srst),
        .uw              (uw),
        .fx              (fx),
        .in_page         (in_page),
        .d_out           (d_out),
        .forced_dispatch (forced_dispatch),
        .dispatch_addr   (dispatch_addr),
        .cs_addr_q       (cs_addr_q),
        .ret_q           (ret_q)
    );

    assign next_micro_address = cs_addr_q;

    // ************************************************************
    // wishbone decode
    // ************************************************************
    logic        ack_q;
    logic [31:0] rdat_q;

    wire hit       = wb_req.cyc & wb_req.stb;
    wire first     = hit & ~ack_q;
    // a write lands on the edge where the master sees ack
    wire wr_commit = hit & wb_req.we & ack_q;
    wire sel_ctrl  = (wb_req.adr == `MBPL_OFS_CTRL);
    wire sel_count = (wb_req.adr == `MBPL_OFS_COUNT);
    wire sel_res   = (wb_req.adr == `MBPL_OFS_RESULT);
    wire sel_route = (wb_req.adr == `MBPL_OFS_ROUTE);
    wire sel_stat  = (wb_req.adr == `MBPL_OFS_STATUS);
    wire sel_track = (wb_req.adr == `MBPL_OFS_TRACK);

    // read views of each register
    wire [31:0] rd_ctrl  = {27'h0000000, short_flags_q, imm_sel_q, track_en_q};
    wire [31:0] rd_count = {24'h000000, loop_counter_q};
    wire [31:0] rd_res   = {16'h0000, result_q};
    wire [31:0] rd_route = {16'h0000, routing_q};
    wire [31:0] rd_stat  = {8'h00, ret_q, cs_addr_q};
    wire [31:0] rd_track = {20'h00000, tracked_addr_q};

    // read mux; unmapped addresses read as zero
    wire [31:0] rd_mux = sel_ctrl  ? rd_ctrl  :
                         sel_count ? rd_count :
                         sel_res   ? rd_res   :
                         sel_route ? rd_route :
                         sel_stat  ? rd_stat  :
                         sel_track ? rd_track :
                         `MBPL_BUS_ZERO;

    // merged write data per register
    wire [31:0] wr_ctrl  = lane_merge(rd_ctrl, wb_req.dat, wb_req.sel);
    wire [31:0] wr_count = lane_merge(rd_count, wb_req.dat, wb_req.sel);
    wire [31:0] wr_res   = lane_merge(rd_res, wb_req.dat, wb_req.sel);
    wire [31:0] wr_route = lane_merge(rd_route, wb_req.dat, wb_req.sel);

    wire we_ctrl  = wr_commit & sel_ctrl;
    wire we_count = wr_commit & sel_count;
    wire we_res   = wr_commit & sel_res;
    wire we_route = wr_commit & sel_route;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_q  <= 1'b0;
            rdat_q <= `MBPL_BUS_ZERO;
        end else begin
            ack_q  <= first;
            rdat_q <= first ? rd_mux : `MBPL_BUS_ZERO;
        end
    end

    assign wb_ack   = ack_q;
    assign wb_dat_r = rdat_q;

    // ************************************************************
    // next values of the machine state
    // ************************************************************
    // software write first, microcode effects override it
    wire [`MBPL_CNT_W-1:0] cnt_sw = we_count ? wr_count[`MBPL_CNT_W-1:0]
                                             : loop_counter_q;
    // test happens on the old value, increment afterwards
    wire [`MBPL_CNT_W-1:0] cnt_d  = fx.ctr_inc ? loop_counter_q + `MBPL_CNT_ONE
                                               : cnt_sw;

    wire track_sw = we_ctrl ? wr_ctrl[`MBPL_CTRL_TRACK] : track_en_q;
    // a dispatch jam wins over enabling in the same cycle
    wire track_d  = forced_dispatch ? 1'b0 :
                    fx.track_on     ? 1'b1 : track_sw;

    wire imm_sw   = we_ctrl ? wr_ctrl[`MBPL_CTRL_IMM] : imm_sel_q;
    wire imm_d    = fx.clear_flags | imm_sw;

    wire [`MBPL_FLAG_W-1:0] flags_sw = we_ctrl ?
        wr_ctrl[`MBPL_CTRL_FL_HI:`MBPL_CTRL_FL_LO] : short_flags_q;
    wire [`MBPL_FLAG_W-1:0] flags_d  = fx.clear_flags ? `MBPL_FLAG_RST : flags_sw;

    wire [`MBPL_WORD_W-1:0] res_sw   = we_res ? wr_res[`MBPL_WORD_W-1:0] : result_q;
    wire [`MBPL_WORD_W-1:0] res_d    = fx.clear_flags ? `MBPL_WORD_RST : res_sw;

    wire [`MBPL_WORD_W-1:0] route_sw = we_route ? wr_route[`MBPL_WORD_W-1:0]
                                                : routing_q;
    wire [`MBPL_WORD_W-1:0] route_d  = fx.clear_flags ? `MBPL_WORD_RST : route_sw;

    // tracking samples the address being executed
    wire [`MBPL_ADDR_W-1:0] trk_d = track_en_q ? cs_addr_q : tracked_addr_q;

    // ************************************************************
    // state registers
    // ************************************************************
    // counter and flags; null and spare codes leave all unchanged
    always_ff @(posedge clk) begin
        if (srst) begin
            loop_counter_q <= `MBPL_CNT_RST;
            short_flags_q  <= `MBPL_FLAG_RST;
            imm_sel_q      <= 1'b0;
        end else begin
            loop_counter_q <= cnt_d;
            short_flags_q  <= flags_d;
            imm_sel_q      <= imm_d;
        end
    end

    // result and routing registers
    always_ff @(posedge clk) begin
        if (srst) begin
            result_q  <= `MBPL_WORD_RST;
            routing_q <= `MBPL_WORD_RST;
        end else begin
            result_q  <= res_d;
            routing_q <= route_d;
        end
    end

    // tracking and source-field force pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            track_en_q     <= 1'b0;
            tracked_addr_q <= `MBPL_ADDR_RST;
            ror1_q         <= 1'b0;
        end else begin
            track_en_q     <= track_d;
            tracked_addr_q <= trk_d;
            ror1_q         <= fx.ror1;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    wire [`MBPL_PAGE_W-1:0] page_now = cs_addr_q[`MBPL_ADDR_W-1:`MBPL_INPAGE_W];
    wire                    no_jam   = ~forced_dispatch;
    wire                    no_sw    = ~wr_commit;

    a_null_keeps:
    assert property ((uw.branch_code_field == `MBPL_BC_NULL) && no_jam && no_sw
        |=> (cs_addr_q[`MBPL_INPAGE_W-1:0] == $past(uw.next_address_field))
            && $stable(page_now) && $stable(loop_counter_q) && $stable(ret_q)
            && $stable(track_en_q) && $stable(result_q))
        else $error("null code altered state or address");

    a_count_exit:
    assert property ((uw.branch_code_field == `MBPL_BC_COUNT) && no_jam
        && (loop_counter_q == `MBPL_CNT_FULL)
        |=> cs_addr_q[0] && (loop_counter_q == `MBPL_CNT_RST))
        else $error("count exit bit or wrap wrong");

    a_count_step:
    assert property ((uw.branch_code_field == `MBPL_BC_COUNT)
        |=> loop_counter_q == $past(loop_counter_q) + `MBPL_CNT_ONE)
        else $error("loop counter did not step");

    a_ror1_pulse:
    assert property ($rose(ror1_q) |-> $past(uw.branch_code_field) == `MBPL_BC_ROR1)
        else $error("source force without its code");

    a_carry_odd:
    assert property ((uw.branch_code_field == `MBPL_BC_CARRY_ODD) && no_jam
        |=> cs_addr_q[1:0] ==
            ($past(uw.next_address_field[1:0]) | {$past(cond.dp_carry),
                                                  $past(cond.bus_addr_lsb)}))
        else $error("carry/odd bits not ORed");

    a_track_jam:
    assert property (forced_dispatch |=> !track_en_q ##1 $stable(tracked_addr_q))
        else $error("tracking survived a dispatch jam");

    a_clear_flags:
    assert property ((uw.branch_code_field == `MBPL_BC_CLEAR)
        |=> (result_q == `MBPL_WORD_RST) && (routing_q == `MBPL_WORD_RST)
            && (short_flags_q == `MBPL_FLAG_RST) && imm_sel_q)
        else $error("clear code left state behind");

    a_call_uword:
    assert property ((uw.branch_code_field == `MBPL_BC_CALL_UW) && no_jam
        |=> (ret_q == {$past(uw.saved_page_field), $past(uw.return_addr_field)})
            && (page_now == $past(uw.page_field)))
        else $error("microword call load wrong");

    a_call_dpath:
    assert property ((uw.branch_code_field == `MBPL_BC_CALL_DP) && no_jam
        |=> (ret_q == $past(d_out[`MBPL_D_RET_HI:`MBPL_D_RET_LO]))
            && (page_now == $past(uw.page_field)))
        else $error("datapath call load wrong");

    a_return_jump:
    assert property ((uw.branch_code_field == `MBPL_BC_RETURN) && no_jam
        |=> (cs_addr_q == $past(ret_q))
            && (ret_q == $past(d_out[`MBPL_D_RET_HI:`MBPL_D_RET_LO])))
        else $error("return did not jump to saved address");

    a_page_hold:
    assert property (no_jam && (uw.branch_code_field != `MBPL_BC_CALL_UW)
        && (uw.branch_code_field != `MBPL_BC_CALL_DP)
        && (uw.branch_code_field != `MBPL_BC_RETURN)
        |=> $stable(page_now))
        else $error("page changed on a non-page code");

    a_wb_answer:
    assert property (first |=> wb_ack ##1 !wb_ack)
        else $error("wishbone ack not a single cycle after request");
endmodule
`default_nettype wire

// file: bench/mbpl_cstore.sv
`include "mbpl_defs.svh"
`default_nettype none
// ************************************************
// control store model
// ************************************************
module mbpl_cstore import mbpl_pkg::*; (
    // address from the sequencer
    input  wire logic [`MBPL_ADDR_W-1:0] addr,
    // fetched microword
    output var  mbpl_uword_t             word
);
    timeunit 1ns;
    timeprecision 1ps;
    mbpl_uword_t mem [4096];
    // blank words hold the null code, the safe default branch
    initial foreach (mem[i]) mem[i] = {`MBPL_BC_NULL, 24'h0};
    // unregistered fetch: the word follows the address at once
    assign word = mem[addr];
endmodule
`default_nettype wire

// file: bench/mbpl_top_test.sv
`include "mbpl_defs.svh"
`default_nettype none
// ************************************************
// sequencer bench
// ************************************************
module mbpl_top_test import mbpl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        mbpl_uword_t w;
        mbpl_cond_t  c;
        logic [15:0] d;
        logic        fd;
        logic [11:0] na;
        logic [7:0]  cnt;
        logic [2:0]  fl;
    } mbpl_row_t;
    localparam mbpl_uword_t null_word = {5'h18, 24'h0};
    logic         clk, srst, forced_dispatch, ror1_q, imm_sel_q, track_en_q, wb_ack;
    mbpl_uword_t  uw;
    mbpl_cond_t   cond;
    mbpl_wb_req_t wb_req;
    logic [15:0]  d_out, result_q, routing_q;
    logic [11:0]  dispatch_addr, next_micro_address;
    logic [7:0]   loop_counter_q;
    logic [2:0]   short_flags_q;
    logic [31:0]  wb_dat_r;
    int           n_errors, n_compared;
    // word, conditions, d, jam, next address, counter, {ror1, imm, track}
    mbpl_row_t rows [16] = '{
        '{{5'h18,9'h055,15'h0},10'h0,16'h0,0,12'h055,8'hfe,0},
        '{{5'h13,9'h100,15'h0},10'h200,16'h0,0,12'h102,8'hfe,0},
        '{{5'h13,9'h003,15'h0},10'h300,16'h0,0,12'h003,8'hfe,0},
        '{{5'h13,9'h000,15'h0},10'h100,16'h0,0,12'h001,8'hfe,0},
        '{{5'h15,9'h010,15'h0},10'h0,16'h0,0,12'h010,8'hff,0},
        '{{5'h15,9'h010,15'h0},10'h0,16'h0,0,12'h011,8'h00,0},
        '{{5'h1b,9'h033,15'h0},10'h0,16'h0,0,12'h033,8'h00,0},
        '{{5'h1e,9'h036,15'h0},10'h0,16'h0,0,12'h036,8'h00,0},
        '{{5'h12,9'h0f0,15'h0},10'h0,16'h0,0,12'h0f0,8'h00,4},
        '{{5'h19,9'h0f1,15'h0},10'h0,16'h0,0,12'h0f1,8'h00,1},
        '{{5'h1c,9'h020,3'h5,3'h3,9'h0aa},10'h0,16'h0,0,12'ha20,8'h00,1},
        '{{5'h1f,9'h1ff,15'h0},10'h0,16'hf87f,0,12'h6aa,8'h00,1},
        '{{5'h1d,9'h044,3'h2,12'h0},10'h0,16'h8918,0,12'h444,8'h00,1},
        '{{5'h1a,9'h0f0,15'h0},10'h0,16'h0,0,12'h4f0,8'h00,3},
        '{{5'h1f,9'h000,15'h0},10'h0,16'h7ff8,0,12'h123,8'h00,3},
        '{{5'h19,9'h077,15'h0},10'h0,16'h0,1,12'h5a5,8'h00,2}};
    mbpl_top dut_u (.clk(clk), .srst(srst), .uw(uw), .cond(cond), .d_out(d_out),
        .forced_dispatch(forced_dispatch), .dispatch_addr(dispatch_addr),
        .next_micro_address(next_micro_address), .ror1_q(ror1_q), .imm_sel_q(imm_sel_q),
        .short_flags_q(short_flags_q), .result_q(result_q), .routing_q(routing_q),
        .loop_counter_q(loop_counter_q), .track_en_q(track_en_q), .tracked_addr_q(),
        .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r));
    mbpl_cstore cs_u (.addr(next_micro_address), .word(uw));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // compare and count
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dw, ex);
        int n;
        n = 0;
        wb_req <= '{1'b1, 1'b1, we, a, 4'hf, dw};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (wb_ack !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        if (!we) chk(wb_dat_r, ex);
        wb_req <= '0;
        @(posedge clk);
    endtask
    // one row executed, then a null cycle to in-page address 0 that keeps the counter and flags
    task automatic step(input mbpl_row_t r);
        logic [11:0] a;
        cond            <= r.c;
        d_out           <= r.d;
        forced_dispatch <= r.fd;
        @(negedge clk);
        a = next_micro_address;
        cs_u.mem[a] = r.w;
        @(posedge clk);
        forced_dispatch <= 1'b0;
        @(negedge clk);
        cs_u.mem[a] = null_word;
        chk(next_micro_address, r.na);
        chk(loop_counter_q, r.cnt);
        chk({ror1_q, imm_sel_q, track_en_q}, r.fl);
        @(posedge clk);
    endtask
    // main sequence
    initial begin
        srst = 1'b1;
        wb_req = '0;
        cond = '0;
        d_out = '0;
        forced_dispatch = 1'b0;
        dispatch_addr = 12'h5a5;
        n_errors = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(next_micro_address, 12'h000);
        chk(loop_counter_q, 8'h00);
        @(posedge clk);
        wb(1'b1, 8'h04, 32'hfe, 0);
        wb(1'b1, 8'h08, 32'h1234, 0);
        wb(1'b1, 8'h0c, 32'habcd, 0);
        wb(1'b1, 8'h00, 32'h1c, 0);
        chk({short_flags_q, result_q, routing_q}, 35'h7_1234_abcd);
        foreach (rows[i]) step(rows[i]);
        chk({short_flags_q, result_q, routing_q}, 0);
        wb(1'b0, 8'h10, 0, 32'h00fff400);
        wb(1'b0, 8'h20, 0, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
